// *** rtl/cisc_pkg.sv ***
package cisc_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;
  localparam int          PERIPH_W       = 8;
  // core register of the unbanked region
  localparam logic [7:0]  FLAGS_EN_ADDR  = 8'h07;
  // extra registers for the interrupt wrapper
  localparam logic [7:0]  EVT_STATUS_ADDR = 8'h40;
  localparam logic [7:0]  EVT_MASK_ADDR   = 8'h41;
  localparam logic [7:0]  CTRL_ADDR       = 8'h42;
  localparam logic [7:0]  PERIPH_EN_ADDR  = 8'h43;
  localparam logic [7:0]  PERIPH_FLAG_ADDR = 8'h44;
  // field positions
  localparam int          PSF_BIT        = 7;
  localparam int          CEF_BIT        = 6;
  localparam int          TOF_BIT        = 5;
  localparam int          EPF_BIT        = 4;
  localparam int          PSE_BIT        = 3;
  localparam int          CEE_BIT        = 2;
  localparam int          TOE_BIT        = 1;
  localparam int          EPE_BIT        = 0;
  localparam int          GID_BIT        = 0;
  // reset values
  localparam logic [7:0]  FLAGS_EN_RST   = 8'h00;
  localparam logic [7:0]  PERIPH_EN_RST  = 8'h00;
  localparam logic [7:0]  CTRL_RST       = 8'h01;
  localparam logic [7:0]  EVT_MASK_RST   = 8'h00;
  // vector addresses
  localparam logic [7:0]  VEC_RESET      = 8'h00;
  localparam logic [7:0]  VEC_EXT_PIN    = 8'h08;
  localparam logic [7:0]  VEC_TIMER0     = 8'h10;
  localparam logic [7:0]  VEC_COUNTER    = 8'h18;
  localparam logic [7:0]  VEC_PERIPH     = 8'h20;
  // event status bits
  localparam int          EV_HAZARD      = 0;
  localparam int          EV_VECTOR      = 1;
endpackage

// *** rtl/cisc_core_irq.sv ***
`timescale 1ns/1ps
module cisc_core_irq #(
  parameter int PERIPH_N = cisc_pkg::PERIPH_W
) (
  input  wire logic                        CLOCK,
  input  wire logic                        RESETN,
  input  wire logic [cisc_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [cisc_pkg::DATA_W-1:0] WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [cisc_pkg::DATA_W-1:0] RDATA,
  input  wire logic                        COUNTER_EDGE,
  input  wire logic                        TIMER_OVERFLOW,
  input  wire logic                        EXT_PIN_EDGE,
  input  wire logic [PERIPH_N-1:0]         PERIPHERAL_FLAGS,
  input  wire logic                        VECTOR_TAKEN,
  output logic                             CORE_IRQ,
  output logic      [cisc_pkg::ADDR_W-1:0] CORE_VECTOR,
  output logic                             RESET_VECTOR,
  output logic                             IRQ
);
  import cisc_pkg::*;

  logic       rst_sync_reg;
  logic       rst_n_reg;
  logic [2:0] flag_reg;       // {cef, tof, epf}; summary is live
  logic [3:0] en_reg;
  logic       gid_reg;
  logic [PERIPH_N-1:0] periph_en_reg;
  logic       psf;
  logic [3:0] flag_all;
  logic [3:0] pend;
  logic       en_clear_hazard;
  logic       wr_flags;
  logic [1:0] evt_status_reg;
  logic [1:0] evt_mask_reg;
  logic [1:0] evt_set;
  logic [7:0] rdata_next;
  logic [7:0] vec_next;

  function automatic logic [7:0] pick_vector(input logic [3:0] p);
    if (p[3])      pick_vector = VEC_PERIPH;
    else if (p[2]) pick_vector = VEC_COUNTER;
    else if (p[1]) pick_vector = VEC_TIMER0;
    else           pick_vector = VEC_EXT_PIN;
  endfunction

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_sync_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_sync_reg <= 1'b1;
      rst_n_reg    <= rst_sync_reg;
    end
  end

  assign wr_flags = WR && (ADDR == FLAGS_EN_ADDR);
  // peripheral summary is live, never stored
  assign psf = |(PERIPHERAL_FLAGS & periph_en_reg);
  assign flag_all = {psf, flag_reg[2:0]};
  // flag AND enable AND global disable clear; peripheral also gated by bit 3
  assign pend = gid_reg ? 4'h0 : (flag_all & en_reg);
  // enable dropped by software in the very cycle its flag stands set
  assign en_clear_hazard = wr_flags && !gid_reg &&
    |(flag_all & en_reg & ~WDATA[PSE_BIT:EPE_BIT]);

  // bits 6..4 sticky; set wins over hardware clear on vectoring
  always_ff @(posedge CLOCK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      flag_reg <= FLAGS_EN_RST[6:4];
    end else begin
      if (wr_flags)
        flag_reg[2:0] <= WDATA[CEF_BIT:EPF_BIT];
      if (VECTOR_TAKEN && CORE_VECTOR == VEC_COUNTER)
        flag_reg[2] <= 1'b0;
      if (VECTOR_TAKEN && CORE_VECTOR == VEC_TIMER0)
        flag_reg[1] <= 1'b0;
      if (VECTOR_TAKEN && CORE_VECTOR == VEC_EXT_PIN)
        flag_reg[0] <= 1'b0;
      if (COUNTER_EDGE)   flag_reg[2] <= 1'b1;
      if (TIMER_OVERFLOW) flag_reg[1] <= 1'b1;
      if (EXT_PIN_EDGE)   flag_reg[0] <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      en_reg <= FLAGS_EN_RST[3:0];
    end else if (wr_flags) begin
      en_reg <= WDATA[PSE_BIT:EPE_BIT];
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      gid_reg       <= CTRL_RST[GID_BIT];
      periph_en_reg <= PERIPH_EN_RST[PERIPH_N-1:0];
      evt_mask_reg  <= EVT_MASK_RST[1:0];
    end else begin
      if (WR && ADDR == CTRL_ADDR)      gid_reg <= WDATA[GID_BIT];
      if (WR && ADDR == PERIPH_EN_ADDR)
        periph_en_reg <= WDATA[PERIPH_N-1:0];
      if (WR && ADDR == EVT_MASK_ADDR)  evt_mask_reg <= WDATA[1:0];
    end
  end

  // core-side request and vector, registered
  always_ff @(posedge CLOCK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      CORE_IRQ     <= 1'b0;
      CORE_VECTOR  <= VEC_RESET;
      RESET_VECTOR <= 1'b0;
    end else begin
      CORE_IRQ     <= (|pend) && !VECTOR_TAKEN;
      CORE_VECTOR  <= vec_next;
      RESET_VECTOR <= en_clear_hazard;
    end
  end

  assign vec_next = en_clear_hazard ? VEC_RESET : pick_vector(pend);

  assign evt_set = {VECTOR_TAKEN, en_clear_hazard};

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge CLOCK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      evt_status_reg <= 2'b00;
    end else begin
      evt_status_reg <= ((WR && ADDR == EVT_STATUS_ADDR) ?
                         (evt_status_reg & ~WDATA[1:0]) : evt_status_reg)
                        | evt_set;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_reg) begin
    if (!rst_n_reg) IRQ <= 1'b0;
    else            IRQ <= |(evt_status_reg & evt_mask_reg);
  end

  always_comb begin
    rdata_next = 8'h00;
    unique case (ADDR)
      FLAGS_EN_ADDR:    rdata_next = {flag_all, en_reg};
      EVT_STATUS_ADDR:  rdata_next = {6'h00, evt_status_reg};
      EVT_MASK_ADDR:    rdata_next = {6'h00, evt_mask_reg};
      CTRL_ADDR:        rdata_next = {7'h00, gid_reg};
      PERIPH_EN_ADDR:   rdata_next = 8'(periph_en_reg);
      PERIPH_FLAG_ADDR: rdata_next = 8'(PERIPHERAL_FLAGS);
      default:          rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n_reg) begin
    if (!rst_n_reg)  RDATA <= 8'h00;
    else if (RD)     RDATA <= rdata_next;
    else             RDATA <= 8'h00;
  end

  // assertions; one clock domain, so shared clocking and reset
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!rst_n_reg);

  // enable field of the write data, kept as a net for $past
  logic [3:0] wdata_en;
  assign wdata_en = WDATA[PSE_BIT:EPE_BIT];

  sequence s_hazard;
    wr_flags && !gid_reg && |(flag_all & en_reg & ~wdata_en);
  endsequence

  sequence s_read_flags;
    RD && ADDR == FLAGS_EN_ADDR;
  endsequence

  sequence s_take_counter;
    VECTOR_TAKEN && CORE_VECTOR == VEC_COUNTER;
  endsequence

  sequence s_take_timer;
    VECTOR_TAKEN && CORE_VECTOR == VEC_TIMER0;
  endsequence

  sequence s_take_ext;
    VECTOR_TAKEN && CORE_VECTOR == VEC_EXT_PIN;
  endsequence

  // no new cause and no software write may refill the flag
  sequence s_quiet(ev);
    !ev && !wr_flags;
  endsequence

  property p_flag_set(ev, fl);
    ev |=> fl;
  endproperty

  counter_flag_set_a:
    assert property (p_flag_set(COUNTER_EDGE, flag_reg[2]))
    else $error("counter flag not set");

  timer_flag_set_a:
    assert property (p_flag_set(TIMER_OVERFLOW, flag_reg[1]))
    else $error("timer flag not set");

  ext_flag_set_a:
    assert property (p_flag_set(EXT_PIN_EDGE, flag_reg[0]))
    else $error("ext pin flag not set");

  counter_flag_clr_a:
    assert property (s_take_counter ##0 s_quiet(COUNTER_EDGE)
      |=> !flag_reg[2])
    else $error("counter flag not cleared");

  timer_flag_clr_a:
    assert property (s_take_timer ##0 s_quiet(TIMER_OVERFLOW)
      |=> !flag_reg[1])
    else $error("timer flag not cleared");

  ext_flag_clr_a:
    assert property (s_take_ext ##0 s_quiet(EXT_PIN_EDGE)
      |=> !flag_reg[0])
    else $error("ext pin flag not cleared");

  reset_vector_a:
    assert property (s_hazard
      |=> RESET_VECTOR && CORE_VECTOR == VEC_RESET)
    else $error("missed reset vector");

  reset_cause_a:
    assert property (RESET_VECTOR
      |-> $past(wr_flags) && !$past(gid_reg))
    else $error("reset vector without cause");

  reset_masked_a:
    assert property (gid_reg |=> !RESET_VECTOR)
    else $error("reset vector while disabled");

  hazard_status_a:
    assert property (s_hazard |=> evt_status_reg[EV_HAZARD])
    else $error("hazard event not recorded");

  summary_read_a:
    assert property (s_read_flags |=> RDATA[PSF_BIT] == $past(psf))
    else $error("summary flag read wrong");

  flags_read_a:
    assert property (s_read_flags
      |=> RDATA[CEF_BIT:EPF_BIT] == $past(flag_reg))
    else $error("flag bits read wrong");

  enables_read_a:
    assert property (s_read_flags
      |=> RDATA[PSE_BIT:EPE_BIT] == $past(en_reg))
    else $error("enable bits read wrong");

  idle_rdata_a:
    assert property (!RD |=> RDATA == 8'h00)
    else $error("read data outside read");

  enable_write_a:
    assert property (wr_flags |=> en_reg == $past(wdata_en))
    else $error("enable write lost");

  enable_hold_a:
    assert property (!wr_flags |=> $stable(en_reg))
    else $error("enable changed without write");

  global_gate_a:
    assert property (gid_reg |=> !CORE_IRQ)
    else $error("request while disabled");

  taken_drop_a:
    assert property (VECTOR_TAKEN |=> !CORE_IRQ)
    else $error("request held over vector");

  taken_status_a:
    assert property (VECTOR_TAKEN |=> evt_status_reg[EV_VECTOR])
    else $error("vector event not recorded");

  timer_enable_a:
    assert property (!gid_reg && flag_reg[1] && en_reg[1] && !VECTOR_TAKEN
      |=> CORE_IRQ)
    else $error("timer request missing");

  timer_vector_a:
    assert property (!gid_reg && flag_reg[1] && en_reg[1] && !en_reg[3]
      && !en_reg[2] && !wr_flags |=> CORE_VECTOR == VEC_TIMER0)
    else $error("timer vector wrong");

  ext_enable_a:
    assert property (!en_reg[0] && !en_reg[1] && !en_reg[2] && !en_reg[3]
      |=> !CORE_IRQ)
    else $error("request with all disabled");

  ext_request_a:
    assert property (!gid_reg && flag_reg[0] && en_reg[0] && !VECTOR_TAKEN
      |=> CORE_IRQ)
    else $error("ext pin request missing");

  ext_vector_a:
    assert property (!gid_reg && flag_reg[0] && en_reg[0] && !en_reg[1]
      && !en_reg[2] && !en_reg[3] && !wr_flags
      |=> CORE_VECTOR == VEC_EXT_PIN)
    else $error("ext pin vector wrong");

  periph_gate_a:
    assert property (!gid_reg && psf && en_reg[3] && !VECTOR_TAKEN
      && !en_clear_hazard |=> CORE_IRQ && CORE_VECTOR == VEC_PERIPH)
    else $error("peripheral request missing");

  periph_block_a:
    assert property (!en_reg[3] && flag_reg == 3'h0 |=> !CORE_IRQ)
    else $error("peripheral not blocked");

  counter_enable_a:
    assert property (!gid_reg && flag_reg[2] && en_reg[2] && !en_reg[3]
      && !wr_flags |=> CORE_VECTOR == VEC_COUNTER)
    else $error("counter vector wrong");

  counter_request_a:
    assert property (!gid_reg && flag_reg[2] && en_reg[2] && !VECTOR_TAKEN
      |=> CORE_IRQ)
    else $error("counter request missing");

  irq_set_a:
    assert property (|(evt_status_reg & evt_mask_reg) |=> IRQ)
    else $error("interrupt output missing");

  irq_clear_a:
    assert property (!(|(evt_status_reg & evt_mask_reg)) |=> !IRQ)
    else $error("interrupt output stuck");
endmodule

// *** dv/cisc_core_seq.sv ***
`timescale 1ns/1ps
module cisc_core_seq (
  input  wire logic       clock,
  input  wire logic       go,
  input  wire logic       core_irq,
  input  wire logic [7:0] core_vector,
  output logic            vector_taken,
  output logic [7:0]      took_vec
);
  logic take;
  // the core vectors only on a live request, one fetch per go
  assign take = go && (core_irq === 1'b1);
  initial vector_taken = 1'b0;
  initial took_vec = 8'h00;
  always @(posedge clock) begin
    vector_taken <= take;
    if (take) took_vec <= core_vector;
  end
endmodule

// *** dv/core_interrupt_status_control_tb.sv ***
`timescale 1ns/1ps
`define CHK(n,e,s) begin n_compared++; if ((s) !== (e)) begin \
  n_fail++; $display("Error %s exp %0h got %0h", n, e, s); end end
module core_interrupt_status_control_tb;
  import cisc_pkg::*;
  logic       clock, resetn, wr, rd, ce, tov, ep, vt, go, irq_c, rv, irq;
  logic [7:0] addr, wdata, pf, rdata, cv, tv;
  int         n_fail, n_compared, cyc, n_rv, i, pen, pfm, fl, en, gid;
  cisc_core_irq cisc_core_irq_i (.CLOCK(clock), .RESETN(resetn),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .COUNTER_EDGE(ce), .TIMER_OVERFLOW(tov), .EXT_PIN_EDGE(ep),
    .PERIPHERAL_FLAGS(pf), .VECTOR_TAKEN(vt), .CORE_IRQ(irq_c),
    .CORE_VECTOR(cv), .RESET_VECTOR(rv), .IRQ(irq));
  cisc_core_seq cisc_core_seq_i (.clock(clock), .go(go), .core_irq(irq_c),
    .core_vector(cv), .vector_taken(vt), .took_vec(tv));
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // hang guard sized well above the run of about 2000 cycles
  always @(posedge clock) begin
    cyc++;
    if (rv === 1'b1) n_rv++;
    if (cyc > 20000) begin
      n_fail++;
      complete_run();
    end
  end
  function automatic int psf();
    return (pfm & pen) != 0;
  endfunction
  function automatic int reg07();
    return (psf() << 7) | (fl << 4) | en;
  endfunction
  function automatic int vec();
    if (en[3] && psf()) return 8'h20;
    if (en[2] && fl[2]) return 8'h18;
    if (en[1] && fl[1]) return 8'h10;
    if (en[0] && fl[0]) return 8'h08;
    return 0;
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) begin
      wr <= 1;
      addr <= a;
      wdata <= d;
    end
    @(posedge clock) wr <= 0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input int e);
    @(posedge clock) begin
      rd <= 1;
      addr <= a;
    end
    @(posedge clock) rd <= 0;
    #1 `CHK("rdata", 8'(e), rdata)
  endtask
  task automatic fire(input int m);
    @(posedge clock) {ce, tov, ep} <= 3'(m);
    @(posedge clock) {ce, tov, ep} <= 3'h0;
    fl = fl | m;
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic check();
    settle();
    `CHK("core_irq", 1'(!gid && vec() != 0), irq_c)
    if (!gid && vec() != 0) `CHK("core_vector", 8'(vec()), cv)
    rd_chk(FLAGS_EN_ADDR, reg07());
  endtask
  task automatic set_gid(input int g);
    gid = g;
    wr_reg(CTRL_ADDR, 8'(g));
  endtask
  task automatic complete_run();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {wr, rd, ce, tov, ep, go, resetn} = 0;
    {addr, wdata, pf} = 0;
    {n_fail, n_compared, cyc, n_rv, pen, pfm, fl, en} = 0;
    gid = 1;
    void'($urandom(6));
    repeat (12) @(posedge clock);
    resetn <= 1;
    repeat (3) @(posedge clock);
    rd_chk(FLAGS_EN_ADDR, 0);
    rd_chk(CTRL_ADDR, 1);
    rd_chk(EVT_MASK_ADDR, 0);
    rd_chk(8'h55, 0);
    $display("test reset done");
    fire(7);
    check();
    $display("test flags done");
    for (i = 0; i < 40; i++) begin
      set_gid(1);
      pfm = $urandom & 255;
      pf <= 8'(pfm);
      pen = $urandom & 255;
      wr_reg(PERIPH_EN_ADDR, 8'(pen));
      fire($urandom & 7);
      en = $urandom & 15;
      // bit 7 written high must be ignored
      wr_reg(FLAGS_EN_ADDR, 8'(reg07() | 8'h80));
      check();
      rd_chk(PERIPH_FLAG_ADDR, pfm);
      rd_chk(PERIPH_EN_ADDR, pen);
      set_gid(0);
      repeat (5) begin
        if (vec() == 8'h20) begin
          pfm = 0;
          @(posedge clock) pf <= 0;
        end else if (vec() != 0) begin
          @(posedge clock) go <= 1;
          @(posedge clock) go <= 0;
          #1 `CHK("took", 8'(vec()), tv)
          fl = fl & ~(1 << (vec() / 8 - 1));
        end
        check();
      end
    end
    $display("test random done");
    set_gid(1);
    pfm = 0;
    pf <= 0;
    fire(2);
    en = 2;
    wr_reg(FLAGS_EN_ADDR, 8'(reg07()));
    en = 0;
    wr_reg(FLAGS_EN_ADDR, 8'(reg07()));
    settle();
    `CHK("hazards", 0, n_rv)
    en = 2;
    wr_reg(FLAGS_EN_ADDR, 8'(reg07()));
    set_gid(0);
    wr_reg(EVT_STATUS_ADDR, 8'h03);
    wr_reg(EVT_MASK_ADDR, 8'h00);
    en = 0;
    wr_reg(FLAGS_EN_ADDR, 8'(reg07()));
    settle();
    `CHK("hazards", 1, n_rv)
    `CHK("irq", 1'b0, irq)
    rd_chk(EVT_STATUS_ADDR, 1);
    wr_reg(EVT_MASK_ADDR, 8'h01);
    settle();
    `CHK("irq", 1'b1, irq)
    wr_reg(EVT_STATUS_ADDR, 8'h01);
    settle();
    `CHK("irq", 1'b0, irq)
    check();
    $display("test hazard done");
    complete_run();
  end
endmodule
